// *** core/dof_pkg.sv ***
// constants, field positions and helper functions for the direct output formatter
// assumes both configuration words are held stable by the control interface
package dof_pkg;

    localparam int unsigned DOF_WORD_W      = 16;
    localparam int unsigned DOF_NUM_TYPES   = 8;
    localparam int unsigned DOF_CLOCK_HZ    = 100_000_000;

    // output_port_config fields
    localparam int unsigned DOF_TAG_LO      = 0;
    localparam int unsigned DOF_TAG_W       = 2;
    localparam int unsigned DOF_DIV_LO      = 14;
    localparam int unsigned DOF_SYNC_LATE   = 17;
    localparam int unsigned DOF_CLK_INV     = 18;
    localparam int unsigned DOF_SYNC_HIGH   = 19;
    localparam int unsigned DOF_SEC_SEL_LO  = 20;
    localparam int unsigned DOF_PRI_SEL_LO  = 22;
    localparam int unsigned DOF_PAR16_OFF   = 25;

    // serial_link_config fields
    localparam int unsigned DOF_COUNT_LO    = 21;
    localparam int unsigned DOF_SRC_ONE_LO  = 25;
    localparam int unsigned DOF_SRC_TWO_LO  = 28;

    // serial word type codes
    localparam logic [2:0] DOF_T_I      = 3'h0;
    localparam logic [2:0] DOF_T_Q      = 3'h1;
    localparam logic [2:0] DOF_T_MAG    = 3'h2;
    localparam logic [2:0] DOF_T_PHASE  = 3'h3;
    localparam logic [2:0] DOF_T_FREQUENCY_WORD   = 3'h4;
    localparam logic [2:0] DOF_T_TIMING = 3'h5;
    localparam logic [2:0] DOF_T_GAIN   = 3'h6;
    localparam logic [2:0] DOF_T_ZERO   = 3'h7;

    // parallel bus source selects
    localparam logic [1:0] DOF_PSEL_I     = 2'h0;
    localparam logic [1:0] DOF_PSEL_MAG   = 2'h1;
    localparam logic [1:0] DOF_PSEL_FREQUENCY_WORD  = 2'h2;
    localparam logic [1:0] DOF_SSEL_Q     = 2'h0;
    localparam logic [1:0] DOF_SSEL_PHASE = 2'h1;
    localparam logic [1:0] DOF_SSEL_MAG   = 2'h2;

    // least significant bit tag codes, 00 and 01 keep the true bit
    localparam logic [1:0] DOF_TAG_ZERO   = 2'h2;
    localparam logic [1:0] DOF_TAG_ONE    = 2'h3;

    localparam logic [3:0] DOF_LAST_BIT   = 4'hf;

    function automatic logic [15:0] dof_tag_word(input logic [15:0] w, input logic [1:0] tag);
        logic [15:0] r;
        r = w;
        if (tag == DOF_TAG_ZERO)
        begin
            r[0] = 1'b0;
        end
        else if (tag == DOF_TAG_ONE)
        begin
            r[0] = 1'b1;
        end
        return r;
    endfunction : dof_tag_word

    // successor field of a word type in the link word; zeros links to zeros
    function automatic logic [2:0] dof_successor(input logic [31:0] link, input logic [2:0] t);
        logic [2:0] r;
        r = DOF_T_ZERO;
        case (t)
            DOF_T_I:      r = link[20:18];
            DOF_T_Q:      r = link[17:15];
            DOF_T_MAG:    r = link[14:12];
            DOF_T_PHASE:  r = link[11:9];
            DOF_T_FREQUENCY_WORD:   r = link[8:6];
            DOF_T_GAIN:   r = link[5:3];
            DOF_T_TIMING: r = link[2:0];
            default:      r = DOF_T_ZERO;
        endcase
        return r;
    endfunction : dof_successor

    // low byte of a parallel bus is blanked when 16-bit mode is off
    function automatic logic [15:0] dof_par_mask(input logic [15:0] w, input logic off16);
        return off16 ? {w[15:8], 8'h00} : w;
    endfunction : dof_par_mask

endpackage : dof_pkg

// *** core/dof_lane_if.sv ***
// link between the chain sequencer and one serial shift lane
// assumes a single clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface dof_lane_if;
    logic        tick;
    logic        load;
    logic [15:0] word;
    logic        bit_out;
    logic        last;

    modport ctrl (output tick, output load, output word, input bit_out, input last);
    modport lane (input tick, input load, input word, output bit_out, output last);
endinterface : dof_lane_if
`default_nettype wire

// *** core/dof_shift_lane.sv ***
// one serial shift lane: loads a word and shifts it msb first on shift ticks
// assumes tick is a one-cycle pulse at the internal shift clock rising edge
`timescale 1ns/1ns
`default_nettype none
module dof_shift_lane
    import dof_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  rst,
    dof_lane_if.lane   lp
);

    logic [15:0] shreg_q;
    logic [3:0]  cnt_q;
    logic        act_q;
    logic        out_q;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            shreg_q <= 16'h0000;
            cnt_q   <= 4'h0;
            act_q   <= 1'b0;
        end
        else if (lp.tick)
        begin
            if (lp.load)
            begin
                shreg_q <= lp.word;
                cnt_q   <= 4'h0;
                act_q   <= 1'b1;
            end
            else if (act_q)
            begin
                shreg_q <= {shreg_q[14:0], 1'b0};
                cnt_q   <= cnt_q + 4'h1;
                if (cnt_q == DOF_LAST_BIT)
                begin
                    act_q <= 1'b0;
                end
            end
        end
    end

    // pin bit held in its own flop so it changes only on a tick
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            out_q <= 1'b0;
        end
        else if (lp.tick)
        begin
            if (lp.load)
            begin
                out_q <= lp.word[15];
            end
            else
            begin
                out_q <= act_q && (cnt_q != DOF_LAST_BIT) && shreg_q[14];
            end
        end
    end

    assign lp.bit_out = out_q;
    assign lp.last    = act_q && (cnt_q == DOF_LAST_BIT);

endmodule : dof_shift_lane
`default_nettype wire

// *** core/dof_top.sv ***
// direct output formatter: parallel direct buses with strobe, dual serial streams
// assumes sample words and strobes come from back-end logic on the same clock
// Function
// - primary bus source from bits 23:22, secondary from bits 21:20 of port config
// - primary carries in-phase, magnitude or frequency; secondary quadrature, phase, magnitude
// - upper bytes always parallel; full 16-bit output when bit 25 is zero
// - active-low strobe low exactly the first cycle a new primary word shows
// - symbol words update once per symbol, frequency at filter output rate
// - in-phase/quadrature aligned; magnitude/phase aligned but one sample later
// - frequency lags by filter delay; strobe then follows decimated filter rate
// - two serial streams of 16-bit words; each type used once overall
// - shift clock is backend clock divided by 1, 2, 4, 8 or 16 (bits 16:14)
// - serial data changes on internal shift clock rise; bit 18 inverts pin clock
// - bit 17 puts sync with each word msb or after its lsb
// - bit 19 selects sync pulse active low or active high
// - bits 13:0 make each type lsb true data, fixed one or fixed zero
// - link bits 24:21 set word count; both streams carry the same count
// - magnitude and gain sent unsigned with leading zero; others two's complement
// - link bits 25:30 hold first word type of each stream
// - type codes: in-phase, quadrature, magnitude, phase, frequency, timing, gain, zeros
// - next word is the successor of the current type until count reached
// - latest frequency repeated every sample until a new filter output
// - successor fields three bits per type from bits 20:18 down to 2:0
// - new sample data preempts the word being shifted; late sync then lost
`timescale 1ns/1ns
`default_nettype none
module dof_top
    import dof_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [31:0] serial_link_config,
    input  wire logic [31:0] output_port_config,
    input  wire logic [15:0] i_word,
    input  wire logic [15:0] q_word,
    input  wire logic [15:0] magnitude_word,
    input  wire logic [15:0] phase_word,
    input  wire logic [15:0] frequency_word,
    input  wire logic [15:0] timing_error_word,
    input  wire logic [15:0] gain_word,
    input  wire logic        sample_valid,
    input  wire logic        frequency_word_valid,
    output logic      [15:0] primary_parallel_bus,
    output logic      [15:0] secondary_parallel_bus,
    output logic             word_valid_strobe_n,
    output logic             serial_stream_one,
    output logic             serial_stream_two,
    output logic             shift_clock_out,
    output logic             word_sync_pulse
);

    typedef enum logic {DOF_CH_IDLE, DOF_CH_RUN} dof_chain_e;

    // configuration fields
    logic [1:0] pri_sel;
    logic [1:0] sec_sel;
    logic       par16_off;
    logic [2:0] div_sel;
    logic       sync_late;
    logic       clk_inv;
    logic       sync_high;
    logic [3:0] word_count;
    logic [2:0] src_one;
    logic [2:0] src_two;

    assign pri_sel    = output_port_config[DOF_PRI_SEL_LO +: 2];
    assign sec_sel    = output_port_config[DOF_SEC_SEL_LO +: 2];
    assign par16_off  = output_port_config[DOF_PAR16_OFF];
    assign div_sel    = output_port_config[DOF_DIV_LO +: 3];
    assign sync_late  = output_port_config[DOF_SYNC_LATE];
    assign clk_inv    = output_port_config[DOF_CLK_INV];
    assign sync_high  = output_port_config[DOF_SYNC_HIGH];
    assign word_count = serial_link_config[DOF_COUNT_LO +: 4];
    assign src_one    = serial_link_config[DOF_SRC_ONE_LO +: 3];
    assign src_two    = serial_link_config[DOF_SRC_TWO_LO +: 3];

    // sample alignment stage
    logic [15:0] mag_d1_q;
    logic [15:0] phase_d1_q;
    logic [15:0] frequency_word_hold_q;

    // polar words held one sample so they trail their cartesian pair
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mag_d1_q   <= 16'h0000;
            phase_d1_q <= 16'h0000;
        end
        else if (sample_valid)
        begin
            mag_d1_q   <= magnitude_word;
            phase_d1_q <= phase_word;
        end
    end

    // last filter output, reused by the serial side every sample
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            frequency_word_hold_q <= 16'h0000;
        end
        else if (frequency_word_valid)
        begin
            frequency_word_hold_q <= frequency_word;
        end
    end

    // parallel direct outputs
    logic        pri_event;
    logic [15:0] pri_value;
    logic [15:0] sec_value;
    logic [15:0] pri_q;
    logic [15:0] sec_q;
    logic        strobe_n_q;

    always_comb
    begin
        pri_event = sample_valid;
        pri_value = i_word;
        case (pri_sel)
            DOF_PSEL_I:
            begin
                pri_value = i_word;
            end
            DOF_PSEL_MAG:
            begin
                pri_value = mag_d1_q;
            end
            DOF_PSEL_FREQUENCY_WORD:
            begin
                pri_event = frequency_word_valid;
                pri_value = frequency_word;
            end
            default:
            begin
                pri_value = i_word;
            end
        endcase
    end

    always_comb
    begin
        case (sec_sel)
            DOF_SSEL_Q:     sec_value = q_word;
            DOF_SSEL_PHASE: sec_value = phase_d1_q;
            DOF_SSEL_MAG:   sec_value = mag_d1_q;
            default:        sec_value = q_word;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pri_q <= 16'h0000;
        end
        else if (pri_event)
        begin
            pri_q <= dof_par_mask(pri_value, par16_off);
        end
    end

    // secondary follows the symbol rate only, so it may skew from the strobe
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sec_q <= 16'h0000;
        end
        else if (sample_valid)
        begin
            sec_q <= dof_par_mask(sec_value, par16_off);
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            strobe_n_q <= 1'b1;
        end
        else
        begin
            strobe_n_q <= ~pri_event;
        end
    end

    assign primary_parallel_bus   = pri_q;
    assign secondary_parallel_bus = sec_q;
    assign word_valid_strobe_n    = strobe_n_q;

    // serial sample set, tagged and formatted at capture
    logic [15:0] raw   [0:DOF_NUM_TYPES-1];
    logic [15:0] snap_q[0:DOF_NUM_TYPES-1];

    always_comb
    begin
        raw[DOF_T_I]      = i_word;
        raw[DOF_T_Q]      = q_word;
        raw[DOF_T_MAG]    = {1'b0, mag_d1_q[14:0]};
        raw[DOF_T_PHASE]  = phase_d1_q;
        raw[DOF_T_FREQUENCY_WORD]   = frequency_word_hold_q;
        raw[DOF_T_TIMING] = timing_error_word;
        raw[DOF_T_GAIN]   = {1'b0, gain_word[14:0]};
        raw[DOF_T_ZERO]   = 16'h0000;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int t = 0; t < DOF_NUM_TYPES; t++)
            begin
                snap_q[t] <= 16'h0000;
            end
        end
        else if (sample_valid)
        begin
            for (int t = 0; t < DOF_NUM_TYPES - 1; t++)
            begin
                snap_q[t] <= dof_tag_word(raw[t],
                    output_port_config[DOF_TAG_LO + DOF_TAG_W * t +: DOF_TAG_W]);
            end
            snap_q[DOF_T_ZERO] <= raw[DOF_T_ZERO];
        end
    end

    // shift clock divider
    logic [4:0] div_n;
    logic [3:0] half_n;
    logic [3:0] div_cnt_q;
    logic [3:0] div_cnt_d;
    logic       tick;
    logic       sclk_q;

    always_comb
    begin
        case (div_sel)
            3'h0:    div_n = 5'h01;
            3'h1:    div_n = 5'h02;
            3'h2:    div_n = 5'h04;
            3'h3:    div_n = 5'h08;
            default: div_n = 5'h10;
        endcase
        half_n    = div_n[4:1];
        tick      = ({1'b0, div_cnt_q} >= (div_n - 5'h01));
        div_cnt_d = tick ? 4'h0 : (div_cnt_q + 4'h1);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            div_cnt_q <= 4'h0;
            sclk_q    <= 1'b0;
        end
        else
        begin
            div_cnt_q <= div_cnt_d;
            sclk_q    <= (div_cnt_d < half_n); // high half starts at each tick
        end
    end

    // divide by one has no slower edge to build, so the backend clock itself goes out
    assign shift_clock_out = ((div_n == 5'h01) ? clock : sclk_q) ^ clk_inv;

    // chain sequencer
    dof_lane_if lane_one ();
    dof_lane_if lane_two ();

    dof_chain_e  chain_q;
    logic [3:0]  idx_q;
    logic [2:0]  type_one_q;
    logic [2:0]  type_two_q;
    logic        start_q;
    logic        load;
    logic        finish;
    logic [2:0]  next_one;
    logic [2:0]  next_two;
    logic        sync_next;
    logic        sync_pin_q;

    always_comb
    begin
        load     = 1'b0;
        finish   = 1'b0;
        next_one = type_one_q;
        next_two = type_two_q;
        if (start_q && (word_count != 4'h0))
        begin
            load     = 1'b1;
            next_one = src_one;
            next_two = src_two;
        end
        else if ((chain_q == DOF_CH_RUN) && lane_one.last)
        begin
            if ((idx_q + 4'h1) < word_count)
            begin
                load     = 1'b1;
                next_one = dof_successor(serial_link_config, type_one_q);
                next_two = dof_successor(serial_link_config, type_two_q);
            end
            else
            begin
                finish = 1'b1;
            end
        end
        // early sync marks the msb period, late sync the period after the lsb
        sync_next = sync_late ? ((chain_q == DOF_CH_RUN) && lane_one.last) : load;
    end

    // a new sample set always wins over clearing the pending start
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            start_q <= 1'b0;
        end
        else if (sample_valid)
        begin
            start_q <= 1'b1;
        end
        else if (tick)
        begin
            start_q <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            chain_q    <= DOF_CH_IDLE;
            idx_q      <= 4'h0;
            type_one_q <= DOF_T_ZERO;
            type_two_q <= DOF_T_ZERO;
        end
        else if (tick)
        begin
            type_one_q <= next_one;
            type_two_q <= next_two;
            if (load)
            begin
                chain_q <= DOF_CH_RUN;
                idx_q   <= (start_q && (word_count != 4'h0)) ? 4'h0 : (idx_q + 4'h1);
            end
            else if (finish)
            begin
                chain_q <= DOF_CH_IDLE;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync_pin_q <= 1'b0;
        end
        else if (tick)
        begin
            sync_pin_q <= sync_next ^ ~sync_high;
        end
    end

    // both lanes share tick and load so streams stay bit aligned
    assign lane_one.tick = tick;
    assign lane_one.load = tick && load;
    assign lane_one.word = snap_q[next_one];
    assign lane_two.tick = tick;
    assign lane_two.load = tick && load;
    assign lane_two.word = snap_q[next_two];

    dof_shift_lane u_lane_one
    (
        .clock (clock),
        .rst   (rst),
        .lp    (lane_one)
    );

    dof_shift_lane u_lane_two
    (
        .clock (clock),
        .rst   (rst),
        .lp    (lane_two)
    );

    assign serial_stream_one = lane_one.bit_out;
    assign serial_stream_two = lane_two.bit_out;
    assign word_sync_pulse   = sync_pin_q;

endmodule : dof_top
`default_nettype wire

// *** bench/dof_top_properties.sv ***
// port checks
// assumes one backend clock
`timescale 1ns/1ns
`default_nettype none
module dof_top_properties (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [31:0] serial_link_config,
    input wire logic [31:0] output_port_config,
    input wire logic [15:0] i_word,
    input wire logic [15:0] q_word,
    input wire logic [15:0] magnitude_word,
    input wire logic        sample_valid,
    input wire logic        frequency_word_valid,
    input wire logic [15:0] primary_parallel_bus,
    input wire logic [15:0] secondary_parallel_bus,
    input wire logic        word_valid_strobe_n,
    input wire logic        serial_stream_one,
    input wire logic        shift_clock_out,
    input wire logic        word_sync_pulse
);
    logic [31:0] opc_q, slc_q;
    logic [15:0] mag_cur_q, mag_prev_q;
    logic [4:0]  age_q;
    logic [1:0]  psel, ssel;
    logic        cfg_chg, pri_ev, sk, off;
    assign psel = output_port_config[23:22];
    assign ssel = output_port_config[21:20];
    assign off = output_port_config[25];
    assign sk = shift_clock_out ^ output_port_config[18];
    assign cfg_chg = (output_port_config != opc_q) || (serial_link_config != slc_q);
    assign pri_ev = (psel == 2'h2) ? frequency_word_valid : sample_valid;
    function automatic logic [15:0] msk(input logic [15:0] w, input logic o);
        return o ? {w[15:8], 8'h00} : w;
    endfunction : msk
    always_ff @(posedge clock)
    begin
        opc_q <= output_port_config;
        slc_q <= serial_link_config;
    end
    // let divider settle after a change
    always_ff @(posedge clock)
    begin
        if (rst || cfg_chg)
            age_q <= 5'h00;
        else if (age_q != 5'h1f)
            age_q <= age_q + 5'h01;
    end
    always_ff @(posedge clock)
    begin
        if (sample_valid)
        begin
            mag_prev_q <= mag_cur_q;
            mag_cur_q  <= magnitude_word;
        end
    end
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (rst || cfg_chg);
    a_strobe_on_event: assert property (pri_ev |=> !word_valid_strobe_n)
        else $error("strobe missing");
    a_strobe_needs_event: assert property (!word_valid_strobe_n |-> $past(pri_ev))
        else $error("stray strobe");
    a_primary_i_src: assert property (sample_valid && psel[0] == psel[1]
        |=> primary_parallel_bus == msk($past(i_word), off))
        else $error("primary not I");
    a_primary_mag_lag: assert property (sample_valid && psel == 2'h1
        |=> primary_parallel_bus == msk(mag_prev_q, off))
        else $error("primary mag lag");
    a_secondary_q_src: assert property (sample_valid && ssel[0] == ssel[1]
        |=> secondary_parallel_bus == msk($past(q_word), off))
        else $error("secondary not Q");
    a_primary_holds: assert property (!pri_ev |=> $stable(primary_parallel_bus))
        else $error("primary moved");
    a_secondary_holds: assert property (!sample_valid |=> $stable(secondary_parallel_bus))
        else $error("secondary moved");
    a_frequency_word_no_sample: assert property (sample_valid && !frequency_word_valid && psel == 2'h2
        |=> word_valid_strobe_n)
        else $error("strobe on sample");
    a_data_on_rise: assert property ($changed(serial_stream_one) && age_q == 5'h1f
        && output_port_config[16:14] != 3'h0 |-> sk)
        else $error("data off clock rise");
    a_div4_period: assert property ($rose(sk) && age_q == 5'h1f && output_port_config[16:14] == 3'h2
        |=> (!$rose(sk)) [*3] ##1 $rose(sk))
        else $error("clock period not 4");
    c_back_to_back: cover property (!word_valid_strobe_n ##1 !word_valid_strobe_n);
    c_frequency_word_path: cover property (frequency_word_valid && psel == 2'h2);
    c_sync_seen: cover property ($rose(word_sync_pulse));
endmodule : dof_top_properties
bind dof_top dof_top_properties chk (.*);
`default_nettype wire

// *** bench/dof_rx_model.sv ***
// serial receiver: frames words on early sync
// assumes data stable at pin clock fall
`timescale 1ns/1ns
`default_nettype none
module dof_rx_model (
    input  wire logic        sclk,
    input  wire logic        sync,
    input  wire logic        sync_high,
    input  wire logic        din_one,
    input  wire logic        din_two,
    input  wire logic        clr,
    output logic      [15:0] got_one [8],
    output logic      [15:0] got_two [8],
    output logic      [3:0]  got_n
);
    logic [15:0] sh_one, sh_two;
    logic [4:0]  bits;
    always @(negedge sclk or posedge clr)
    begin
        if (clr)
        begin
            bits  <= 5'h00;
            got_n <= 4'h0;
        end
        else if (sync == sync_high)
        begin
            sh_one <= {15'h0, din_one};
            sh_two <= {15'h0, din_two};
            bits   <= 5'h01;
        end
        else if (bits != 5'h00 && bits != 5'h10)
        begin
            sh_one <= {sh_one[14:0], din_one};
            sh_two <= {sh_two[14:0], din_two};
            bits   <= bits + 5'h01;
            if (bits == 5'h0f && got_n < 4'h8)
            begin
                got_one[got_n[2:0]] <= {sh_one[14:0], din_one};
                got_two[got_n[2:0]] <= {sh_two[14:0], din_two};
                got_n <= got_n + 4'h1;
            end
        end
    end
endmodule : dof_rx_model
`default_nettype wire

// *** bench/dof_top_tb_top.sv ***
// bench for the output formatter
// assumes bound checker and receiver model
`timescale 1ns/1ns
`default_nettype none
module dof_top_tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] slc = 32'h0;
    logic [31:0] opc = 32'h0;
    logic [15:0] iw, qw, mw, pw;
    logic [15:0] fw, tw, gw;
    logic        sv = 1'b0, fv = 1'b0, clr = 1'b0;
    logic [15:0] pri, sec;
    logic        stb_n, so1, so2, sck, syn;
    logic [15:0] got_one [8];
    logic [15:0] got_two [8];
    logic [3:0]  got_n;
    int          error_cnt = 0;
    int          checks_done = 0;
    always #5 clock = ~clock;
    dof_top uut (.clock(clock), .rst(rst), .serial_link_config(slc), .output_port_config(opc),
        .i_word(iw), .q_word(qw), .magnitude_word(mw), .phase_word(pw), .frequency_word(fw),
        .timing_error_word(tw), .gain_word(gw), .sample_valid(sv), .frequency_word_valid(fv),
        .primary_parallel_bus(pri), .secondary_parallel_bus(sec), .word_valid_strobe_n(stb_n),
        .serial_stream_one(so1), .serial_stream_two(so2), .shift_clock_out(sck),
        .word_sync_pulse(syn));
    dof_rx_model rx (.sclk(sck), .sync(syn), .sync_high(opc[19]), .din_one(so1),
        .din_two(so2), .clr(clr), .got_one(got_one), .got_two(got_two), .got_n(got_n));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic words(input logic [7:0] k);
        {iw, qw, mw, pw} = {8'h1a, k, 8'h2b, k, 8'h3c, k, 8'h4d, k};
    endtask : words
    // two samples per select; polar words lag one
    task automatic t_parallel;
        logic [1:0] ps;
        for (int s = 0; s < 4; s++)
        begin
            ps = (s == 2) ? 2'h3 : 2'(s);
            @(negedge clock);
            opc = {6'h0, s == 3, 1'b0, ps, 2'(s), 20'h0};
            words(8'h01);
            sv = 1'b1;
            @(negedge clock);
            words(8'h02);
            check(16'(stb_n), 16'h0);
            @(negedge clock);
            sv = 1'b0;
            check(16'(stb_n), 16'h0);
            check(pri, ps == 2'h1 ? 16'h3c01 : s == 3 ? 16'h1a00 : 16'h1a02);
            check(sec, s == 1 ? 16'h4d01 : s == 2 ? 16'h3c01 : s == 3 ? 16'h2b00 : 16'h2b02);
            @(negedge clock);
            check(16'(stb_n), 16'h1);
        end
    endtask : t_parallel
    task automatic t_frequency_word;
        @(negedge clock);
        opc = 32'h0080_0000;
        fw = 16'h5e5e;
        mw = 16'hf00f;
        sv = 1'b1;
        @(negedge clock);
        sv = 1'b0;
        check(16'(stb_n), 16'h1);
        fv = 1'b1;
        @(negedge clock);
        fv = 1'b0;
        check(16'(stb_n), 16'h0);
        check(pri, 16'h5e5e);
        @(negedge clock);
        check(16'(stb_n), 16'h1);
    endtask : t_frequency_word
    // first rise may be short; time rises two to three
    task automatic t_divider;
        int r, t1, t2;
        logic p, c;
        for (int d = 1; d < 5; d++)
        begin
            @(negedge clock);
            opc = {13'h0, d[0], 1'b0, 3'(d), 14'h0};
            r = 0;
            t2 = 0;
            p = 1'b1;
            for (int k = 0; k < 80 && r < 3; k++)
            begin
                @(negedge clock);
                c = sck ^ opc[18];
                if (c && !p)
                begin
                    r++;
                    t1 = t2;
                    t2 = k;
                end
                p = c;
            end
            if (r < 3)
            begin
                error_cnt++;
                stop_test();
            end
            check(16'(t2 - t1), 16'(1 << d));
        end
    endtask : t_divider
    task automatic t_serial;
        @(negedge clock);
        slc = 32'h2085_cf7e;
        opc = 32'h0008_400b;
        clr = 1'b1;
        fw = 16'h6789;
        fv = 1'b1;
        @(negedge clock);
        clr = 1'b0;
        fv = 1'b0;
        fw = 16'h1111;
        {iw, qw, tw, gw} = {16'h8a50, 16'h1235, 16'hbeef, 16'h9abc};
        sv = 1'b1;
        @(negedge clock);
        sv = 1'b0;
        for (int k = 0; k < 400 && got_n !== 4'h4; k++)
            @(negedge clock);
        check({12'h0, got_n}, 16'h4);
        if (got_n !== 4'h4)
            stop_test();
        check(got_one[0], 16'h8a51);
        check(got_one[1], 16'h1234);
        check(got_one[2], 16'h4d02);
        check(got_one[3], 16'h0000);
        check(got_two[0], 16'h700f);
        check(got_two[1], 16'h6789);
        check(got_two[2], 16'hbeef);
        check(got_two[3], 16'h1abc);
    endtask : t_serial
    task automatic t_late;
        int first = -1, width = 0;
        @(negedge clock);
        slc = 32'h0020_0000;
        opc = 32'h0006_4000;
        repeat (4) @(negedge clock);
        sv = 1'b1;
        @(negedge clock);
        sv = 1'b0;
        for (int k = 0; k < 60; k++)
        begin
            @(negedge clock);
            if (syn === 1'b0)
            begin
                width++;
                if (first < 0)
                    first = k;
            end
        end
        check(16'(width), 16'h2);
        check({15'h0, first > 30}, 16'h1);
    endtask : t_late
    initial
    begin
        repeat (16) @(negedge clock);
        rst = 1'b0;
        t_parallel();
        $display("parallel done");
        t_frequency_word();
        $display("frequency done");
        t_divider();
        $display("divider done");
        t_serial();
        $display("serial done");
        t_late();
        $display("late sync done");
        stop_test();
    end
endmodule : dof_top_tb_top
`default_nettype wire
